// File: hdl/pdc_pkg.sv
// package: register map, field positions and carrier types of the dma channel registers
package pdc_pkg;
    localparam logic [5:0] OFF_RX_CUR_PTR = 6'h00;
    localparam logic [5:0] OFF_RX_CUR_CNT = 6'h04;
    localparam logic [5:0] OFF_TX_PTR = 6'h08;
    localparam logic [5:0] OFF_TX_CNT = 6'h0c;
    localparam logic [5:0] OFF_RX_NPTR = 6'h10;
    localparam logic [5:0] OFF_RX_NCNT = 6'h14;
    localparam logic [5:0] OFF_TX_NPTR = 6'h18;
    localparam logic [5:0] OFF_TX_NCNT = 6'h1c;
    localparam logic [5:0] OFF_CTRL = 6'h20;
    localparam logic [5:0] OFF_STAT = 6'h24;
    localparam int BIT_RX_EN = 0;
    localparam int BIT_RX_DIS = 1;
    localparam int BIT_TX_EN = 8;
    localparam int BIT_TX_DIS = 9;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // one channel's pointer and counter pair
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] count;
    } pdc_buf_t;

    // flags returned to the peripheral
    typedef struct packed {
        logic rx_end_flag;
        logic tx_end_flag;
        logic rx_all_full_flag;
        logic tx_all_empty_flag;
    } pdc_flags_t;
endpackage

// File: hdl/pdc_channel_regs.sv
// peripheral dma channel pair: registers, enables, pointer advance and buffer chaining
`timescale 1ns/1ps
module pdc_channel_regs #(
    parameter bit HALF_DUPLEX = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_item_done,
    input wire logic tx_item_done,
    input wire logic [1:0] item_size,
    output logic rx_req_enable_o,
    output logic tx_req_enable_o,
    output logic [31:0] rx_mem_addr,
    output logic [31:0] tx_mem_addr,
    output pdc_pkg::pdc_flags_t flags
);
    // pointer step per transferred item
    function automatic logic [31:0] step_of(input logic [1:0] sz);
        step_of = (sz == pdc_pkg::SIZE_WORD) ? 32'h0000_0004 :
                  (sz == pdc_pkg::SIZE_HALF) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction

    pdc_pkg::pdc_buf_t rx_cur_q, rx_cur_d, rx_nxt_q, rx_nxt_d;
    pdc_pkg::pdc_buf_t tx_cur_q, tx_cur_d, tx_nxt_q, tx_nxt_d;
    logic rx_en_q, rx_en_d, tx_en_q, tx_en_d;
    logic wr_pend_q;
    logic [5:0] wr_off_q;
    logic [31:0] rdata_q;
    pdc_pkg::pdc_flags_t flags_q;

    // address phase decode
    wire addr_take = hsel && hready && htrans == pdc_pkg::HTRANS_NONSEQ;
    wire [5:0] a_off = haddr[5:0];
    wire wr_ptr_rc = wr_pend_q && wr_off_q == pdc_pkg::OFF_RX_CUR_PTR;
    wire wr_cnt_rc = wr_pend_q && wr_off_q == pdc_pkg::OFF_RX_CUR_CNT;
    wire wr_ptr_tc = wr_pend_q && wr_off_q == pdc_pkg::OFF_TX_PTR;
    wire wr_cnt_tc = wr_pend_q && wr_off_q == pdc_pkg::OFF_TX_CNT;
    wire wr_ptr_rn = wr_pend_q && wr_off_q == pdc_pkg::OFF_RX_NPTR;
    wire wr_cnt_rn = wr_pend_q && wr_off_q == pdc_pkg::OFF_RX_NCNT;
    wire wr_ptr_tn = wr_pend_q && wr_off_q == pdc_pkg::OFF_TX_NPTR;
    wire wr_cnt_tn = wr_pend_q && wr_off_q == pdc_pkg::OFF_TX_NCNT;
    wire wr_ctrl = wr_pend_q && wr_off_q == pdc_pkg::OFF_CTRL;
    // half duplex folds both names onto one storage
    wire hd = HALF_DUPLEX;
    wire w_cur_ptr_rx = wr_ptr_rc || (hd && wr_ptr_tc);
    wire w_cur_ptr_tx = wr_ptr_tc || (hd && wr_ptr_rc);
    wire w_cur_cnt_rx = wr_cnt_rc || (hd && wr_cnt_tc);
    wire w_cur_cnt_tx = wr_cnt_tc || (hd && wr_cnt_rc);
    wire w_nxt_ptr_rx = wr_ptr_rn || (hd && wr_ptr_tn);
    wire w_nxt_ptr_tx = wr_ptr_tn || (hd && wr_ptr_rn);
    wire w_nxt_cnt_rx = wr_cnt_rn || (hd && wr_cnt_tn);
    wire w_nxt_cnt_tx = wr_cnt_tn || (hd && wr_cnt_rn);

    // control bits of the write data
    wire c_rx_en = wr_ctrl && hwdata[pdc_pkg::BIT_RX_EN];
    wire c_rx_dis = wr_ctrl && hwdata[pdc_pkg::BIT_RX_DIS];
    wire c_tx_en = wr_ctrl && hwdata[pdc_pkg::BIT_TX_EN];
    wire c_tx_dis = wr_ctrl && hwdata[pdc_pkg::BIT_TX_DIS];

    // enable update; disables win over enables, zero bits do nothing
    always_comb begin
        rx_en_d = rx_en_q;
        tx_en_d = tx_en_q;
        if (c_rx_en && !c_rx_dis) begin
            rx_en_d = 1'b1;
            if (hd) begin
                tx_en_d = 1'b0;
            end
        end
        if (c_tx_en && !c_tx_dis && !(hd && c_rx_en)) begin
            tx_en_d = 1'b1;
        end
        if (c_rx_dis) begin
            rx_en_d = 1'b0;
            if (hd) begin
                tx_en_d = 1'b0;
            end
        end
        if (c_tx_dis) begin
            tx_en_d = 1'b0;
            if (hd) begin
                rx_en_d = 1'b0;
            end
        end
    end

    // activity: enabled channel with a nonzero count moves an item
    wire rx_go = rx_en_q && rx_item_done && rx_cur_q.count != pdc_pkg::CNT_RESET;
    wire tx_go = tx_en_q && tx_item_done && tx_cur_q.count != pdc_pkg::CNT_RESET;
    wire hd_go = rx_go || tx_go;
    wire rx_step = hd ? hd_go : rx_go;
    wire tx_step = hd ? hd_go : tx_go;
    wire [31:0] step = step_of(item_size);

    // one channel's pointer/count next state; software writes beat hardware steps
    function automatic pdc_pkg::pdc_buf_t cur_next(
        input pdc_pkg::pdc_buf_t cur, input pdc_pkg::pdc_buf_t nxt,
        input logic go, input logic [31:0] stp,
        input logic wp, input logic wc, input logic [31:0] wd);
        pdc_pkg::pdc_buf_t r;
        r = cur;
        if (go) begin
            r.addr = cur.addr + stp;
            r.count = cur.count - 16'h0001;
            if (r.count == pdc_pkg::CNT_RESET && nxt.count != pdc_pkg::CNT_RESET) begin
                r = nxt;
            end
        end
        if (wp) begin
            r.addr = wd;
        end
        if (wc) begin
            r.count = wd[15:0];
        end
        cur_next = r;
    endfunction

    // true when this step empties current and chains in the next pair
    function automatic logic chains(input pdc_pkg::pdc_buf_t cur,
        input pdc_pkg::pdc_buf_t nxt, input logic go);
        chains = go && cur.count == 16'h0001 && nxt.count != pdc_pkg::CNT_RESET;
    endfunction

    wire rx_chain = chains(rx_cur_q, rx_nxt_q, rx_step);
    wire tx_chain = chains(tx_cur_q, tx_nxt_q, tx_step);

    // next pair: written by software, zeroed when copied into current
    always_comb begin
        rx_cur_d = cur_next(rx_cur_q, rx_nxt_q, rx_step, step, w_cur_ptr_rx, w_cur_cnt_rx, hwdata);
        tx_cur_d = cur_next(tx_cur_q, tx_nxt_q, tx_step, step, w_cur_ptr_tx, w_cur_cnt_tx, hwdata);
        rx_nxt_d = rx_nxt_q;
        tx_nxt_d = tx_nxt_q;
        if (rx_chain) begin
            rx_nxt_d = '0;
        end
        if (tx_chain) begin
            tx_nxt_d = '0;
        end
        if (w_nxt_ptr_rx) begin
            rx_nxt_d.addr = hwdata;
        end
        if (w_nxt_cnt_rx) begin
            rx_nxt_d.count = hwdata[15:0];
        end
        if (w_nxt_ptr_tx) begin
            tx_nxt_d.addr = hwdata;
        end
        if (w_nxt_cnt_tx) begin
            tx_nxt_d.count = hwdata[15:0];
        end
    end

    // read mux: unmapped, write-only and reserved bits return zero
    wire [31:0] rd_mux =
        (a_off == pdc_pkg::OFF_RX_CUR_PTR) ? rx_cur_q.addr :
        (a_off == pdc_pkg::OFF_RX_CUR_CNT) ? {16'h0000, rx_cur_q.count} :
        (a_off == pdc_pkg::OFF_TX_PTR) ? tx_cur_q.addr :
        (a_off == pdc_pkg::OFF_TX_CNT) ? {16'h0000, tx_cur_q.count} :
        (a_off == pdc_pkg::OFF_RX_NPTR) ? rx_nxt_q.addr :
        (a_off == pdc_pkg::OFF_RX_NCNT) ? {16'h0000, rx_nxt_q.count} :
        (a_off == pdc_pkg::OFF_TX_NPTR) ? tx_nxt_q.addr :
        (a_off == pdc_pkg::OFF_TX_NCNT) ? {16'h0000, tx_nxt_q.count} :
        (a_off == pdc_pkg::OFF_STAT) ? {23'h000000, tx_en_q, 7'h00, rx_en_q} :
        32'h0000_0000;
    wire rd_hit = addr_take && !hwrite && haddr[31:6] == 26'h0000000;
    wire wr_hit = addr_take && hwrite && haddr[31:6] == 26'h0000000;

    // flags follow the counts, so a nonzero current count write clears them at once
    wire [3:0] flags_d = {rx_cur_d.count == pdc_pkg::CNT_RESET,
                          tx_cur_d.count == pdc_pkg::CNT_RESET,
                          rx_cur_d.count == pdc_pkg::CNT_RESET &&
                          rx_nxt_d.count == pdc_pkg::CNT_RESET,
                          tx_cur_d.count == pdc_pkg::CNT_RESET &&
                          tx_nxt_d.count == pdc_pkg::CNT_RESET};

    // channel state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_cur_q <= '0;
            tx_cur_q <= '0;
            rx_nxt_q <= '0;
            tx_nxt_q <= '0;
            rx_en_q <= 1'b0;
            tx_en_q <= 1'b0;
            flags_q <= 4'hf;
        end else begin
            rx_cur_q <= rx_cur_d;
            tx_cur_q <= tx_cur_d;
            rx_nxt_q <= rx_nxt_d;
            tx_nxt_q <= tx_nxt_d;
            rx_en_q <= rx_en_d;
            tx_en_q <= tx_en_d;
            flags_q <= flags_d;
        end
    end

    // bus slave: zero wait states, write data used in the data phase
    // hsize is not decoded: every register is one whole word, so narrow
    // writes land as full words; software must stick to word accesses
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 6'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_hit;
            wr_off_q <= a_off;
            rdata_q <= rd_hit ? rd_mux : 32'h0000_0000;
        end
    end

    // outputs: read data and channel state straight from their registers
    assign hrdata = rdata_q;
    assign hreadyout = 1'b1; // constant, never a wait state
    assign hresp = 1'b0; // always okay
    assign rx_req_enable_o = rx_en_q;
    assign tx_req_enable_o = tx_en_q;
    assign rx_mem_addr = rx_cur_q.addr;
    assign tx_mem_addr = tx_cur_q.addr;
    assign flags = flags_q;

    // item steps and chain copies, each free of a software write in the way
    sequence seq_tx_item;
        tx_go && !hd && !tx_chain && !w_cur_ptr_tx;
    endsequence
    // receive side of the same step, full duplex only
    sequence seq_rx_item;
        rx_go && !hd && !rx_chain && !w_cur_ptr_rx;
    endsequence
    // receive current runs dry and the next pair moves in
    sequence seq_rx_chain;
        rx_chain && !wr_pend_q;
    endsequence
    // transmit current runs dry and the next pair moves in
    sequence seq_tx_chain;
        tx_chain && !wr_pend_q;
    endsequence

    // receive enable lands unless a disable rides in the same write
    chk_rx_en_set: assert property (
        @(posedge clock) disable iff (reset)
        c_rx_en && !c_rx_dis && !c_tx_dis |=> rx_en_q
    ) else $error("rx enable write did not enable");
    // receive disable always clears
    chk_rx_dis_clr: assert property (
        @(posedge clock) disable iff (reset)
        c_rx_dis |=> !rx_en_q
    ) else $error("rx disable write did not clear");
    // transmit enable lands unless a disable or a half duplex rx enable joins it
    chk_tx_en_set: assert property (
        @(posedge clock) disable iff (reset)
        c_tx_en && !c_tx_dis && !c_rx_dis && !(hd && c_rx_en) |=> tx_en_q
    ) else $error("tx enable write did not enable");
    // transmit disable clears, and in half duplex takes receive along
    chk_tx_dis_clr: assert property (
        @(posedge clock) disable iff (reset)
        c_tx_dis |=> !tx_en_q && (!hd || !rx_en_q)
    ) else $error("tx disable write did not clear");
    // half duplex: any receive enable or disable leaves transmit off
    chk_hd_rx_excl: assert property (
        @(posedge clock) disable iff (reset)
        hd && (c_rx_en || c_rx_dis) |=> !tx_en_q
    ) else $error("half duplex rx write left tx enabled");
    // a control write of zeros leaves both enables alone
    chk_zero_writes: assert property (
        @(posedge clock) disable iff (reset)
        wr_ctrl && !c_rx_en && !c_rx_dis && !c_tx_en && !c_tx_dis
        |=> $stable(rx_en_q) && $stable(tx_en_q)
    ) else $error("zero control write changed enables");

    // status read returns the enables as they stood at the address phase
    chk_stat_read: assert property (
        @(posedge clock) disable iff (reset)
        rd_hit && a_off == pdc_pkg::OFF_STAT
        |=> hrdata == {23'h000000, $past(tx_en_q), 7'h00, $past(rx_en_q)}
    ) else $error("status read wrong");
    // transmit pointer moves by the item size
    chk_ptr_step: assert property (
        @(posedge clock) disable iff (reset)
        seq_tx_item |=> tx_cur_q.addr == $past(tx_cur_q.addr) + $past(step)
    ) else $error("tx pointer did not advance");
    // receive pointer moves by the item size
    chk_rx_ptr_step: assert property (
        @(posedge clock) disable iff (reset)
        seq_rx_item |=> rx_cur_q.addr == $past(rx_cur_q.addr) + $past(step)
    ) else $error("rx pointer did not advance");

    // receive chaining copies the next pair and zeroes it
    chk_chain_copy: assert property (
        @(posedge clock) disable iff (reset)
        seq_rx_chain |=> rx_cur_q == $past(rx_nxt_q) && rx_nxt_q.count == 16'h0000
    ) else $error("rx chain copy wrong");
    // transmit chaining copies the next pair and zeroes it
    chk_tx_chain_zero: assert property (
        @(posedge clock) disable iff (reset)
        seq_tx_chain |=> tx_cur_q == $past(tx_nxt_q) && tx_nxt_q.count == 16'h0000
    ) else $error("tx chain copy wrong");
    // a zero current count freezes that channel's pointer and count
    chk_zero_halts: assert property (
        @(posedge clock) disable iff (reset)
        tx_cur_q.count == pdc_pkg::CNT_RESET && !w_cur_ptr_tx && !w_cur_cnt_tx
        |=> $stable(tx_cur_q)
    ) else $error("tx moved with a zero count");

    // transmit empty flag tracks both counts
    chk_empty_flag: assert property (
        @(posedge clock) disable iff (reset)
        tx_cur_q.count == 16'h0000 && tx_nxt_q.count == 16'h0000 |-> flags_q.tx_all_empty_flag
    ) else $error("tx empty flag missing");
    // receive full flag tracks both counts
    chk_rx_full_flag: assert property (
        @(posedge clock) disable iff (reset)
        flags_q.rx_all_full_flag == (rx_cur_q.count == 16'h0000 && rx_nxt_q.count == 16'h0000)
    ) else $error("rx full flag wrong");
    // receive end flag tracks the current count
    chk_rx_end_flag: assert property (
        @(posedge clock) disable iff (reset)
        flags_q.rx_end_flag == (rx_cur_q.count == pdc_pkg::CNT_RESET)
    ) else $error("rx end flag wrong");
    // transmit end flag tracks the current count
    chk_tx_end_flag: assert property (
        @(posedge clock) disable iff (reset)
        flags_q.tx_end_flag == (tx_cur_q.count == pdc_pkg::CNT_RESET)
    ) else $error("tx end flag wrong");

    // upper half of the transmit next count word reads zero
    chk_cnt_hi_zero: assert property (
        @(posedge clock) disable iff (reset)
        rd_hit && a_off == pdc_pkg::OFF_TX_NCNT |=> hrdata[31:16] == 16'h0000
    ) else $error("reserved bits nonzero");
    // read data is zero outside a read data phase
    chk_read_idle: assert property (
        @(posedge clock) disable iff (reset)
        !rd_hit |=> hrdata == 32'h0000_0000
    ) else $error("read data not zero when idle");
    // half duplex keeps the two names on one storage
    chk_shared_store: assert property (
        @(posedge clock) disable iff (reset)
        hd |-> rx_cur_q == tx_cur_q && rx_nxt_q == tx_nxt_q
    ) else $error("half duplex copies differ");
    // first edge out of reset sees both enables cleared
    chk_reset_clear: assert property (
        @(posedge clock)
        $fell(reset) |-> !rx_en_q && !tx_en_q && hrdata == 32'h0000_0000
    ) else $error("enables not cleared after reset");
endmodule

// File: sim/pdc_periph_model.sv
// behavioural serial peripheral: moves one item per request after a random gap
`timescale 1ns/1ps
module pdc_periph_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic enable,
    input wire logic stop,
    input wire logic [3:0] gap,
    output logic done
);
    logic [3:0] wait_q;

    // a gap of zero or one answers every other cycle, a larger gap answers once every gap plus one cycles
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_q <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= enable && !stop && wait_q == 4'h0 && !done;
            wait_q <= (enable && wait_q != 4'h0) ? wait_q - 4'h1 : gap;
        end
    end
endmodule

// File: sim/test_peripheral_dma_channel_regs.sv
// self-checking bench: register access, enable control and buffer chaining
`timescale 1ns/1ps
module test_peripheral_dma_channel_regs;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic sel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic [1:0] item_size = 2'h0;
    logic [3:0] gap = 4'h0;
    logic [31:0] rd0, rd1, d, rx_addr, tx_addr;
    logic ro0, ro1, rx_en0, tx_en0, rx_en1, tx_en1, rx_done, tx_done, hready;
    pdc_pkg::pdc_flags_t flags0;
    logic [1:0] st [2];
    int errors = 0;
    int n_compared = 0;

    // one slave answers at a time, so its hreadyout is the bus hready
    assign hready = sel ? ro1 : ro0;

    pdc_channel_regs #(.HALF_DUPLEX(1'b0)) pdc_channel_regs_inst (
        .clock(clock), .reset(reset), .hsel(!sel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(rd0),
        .hreadyout(ro0), .hresp(), .rx_item_done(rx_done), .tx_item_done(tx_done),
        .item_size(item_size), .rx_req_enable_o(rx_en0), .tx_req_enable_o(tx_en0),
        .rx_mem_addr(rx_addr), .tx_mem_addr(tx_addr), .flags(flags0));
    // half-duplex twin on the same bus; either item strobe steps its one channel
    pdc_channel_regs #(.HALF_DUPLEX(1'b1)) pdc_channel_regs_hd_inst (
        .clock(clock), .reset(reset), .hsel(sel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(rd1),
        .hreadyout(ro1), .hresp(), .rx_item_done(rx_done), .tx_item_done(tx_done),
        .item_size(item_size), .rx_req_enable_o(rx_en1), .tx_req_enable_o(tx_en1),
        .rx_mem_addr(), .tx_mem_addr(), .flags());
    pdc_periph_model rx_model_inst (.clock(clock), .reset(reset), .enable(rx_en0),
        .stop(flags0.rx_end_flag), .gap(gap), .done(rx_done));
    pdc_periph_model tx_model_inst (.clock(clock), .reset(reset), .enable(tx_en0),
        .stop(flags0.tx_end_flag), .gap(~gap), .done(tx_done));

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // address phase held until hready, then idle for the data phase
    task automatic bus_req(input bit p, input logic [5:0] a, input logic w);
        @(posedge clock);
        sel <= p;
        haddr <= {26'h0, a};
        htrans <= pdc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clock); while (!hready);
        htrans <= 2'h0;
    endtask

    task automatic bus_wr(input bit p, input logic [5:0] a, input logic [31:0] w);
        bus_req(p, a, 1'b1);
        hwdata <= w;
        do @(posedge clock); while (!hready);
    endtask

    task automatic bus_rd(input bit p, input logic [5:0] a, output logic [31:0] r);
        bus_req(p, a, 1'b0);
        do @(posedge clock); while (!hready);
        r = p ? rd1 : rd0;
    endtask

    // expected {tx, rx} enables after a control write c = {txdis, txen, rxdis, rxen}
    function automatic logic [1:0] nxt(input bit hd, input logic [1:0] s, input logic [3:0] c);
        if (!hd) return {c[3] ? 1'b0 : (c[2] | s[1]), c[1] ? 1'b0 : (c[0] | s[0])};
        if (c[1] | c[3]) return 2'b00;
        if (c[0]) return 2'b01;
        return c[2] ? {1'b1, s[0]} : s;
    endfunction

    initial begin
        logic [31:0] v;
        logic [31:0] step;
        logic [3:0] c;
        bit p;
        v = $urandom(3);
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        // reset contents, control reads zero, unmapped word at 0x28
        for (int i = 0; i < 11; i++) begin
            bus_rd(1'b0, 6'(4 * i), d);
            chk("reset value", d, 32'h0);
        end
        chk("reset flags", 32'(flags0), 32'hf);
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            bus_wr(1'b0, 6'(4 * i), v);
            bus_rd(1'b0, 6'(4 * i), d);
            chk("read back", d, i[0] ? (v & 32'hffff) : v);
        end
        bus_wr(1'b0, pdc_pkg::OFF_STAT, 32'h0101);
        bus_rd(1'b0, pdc_pkg::OFF_STAT, d);
        chk("status write", d, 32'h0);
        // half duplex: the transmit name and the receive name hold one value
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'hffff;
            bus_wr(1'b1, 6'({i[1], 1'b1, i[0], 2'b00}), v);
            bus_rd(1'b1, 6'({i[1], 1'b0, i[0], 2'b00}), d);
            chk("shared reg", d, v);
        end
        // every control code on both instances (half duplex drops tx enable beside rx enable), then random ones
        st[0] = 2'b00;
        st[1] = 2'b00;
        for (int k = 0; k < 96; k++) begin
            p = k[0];
            c = (k < 32) ? 4'(k >> 1) : 4'($urandom);
            if (p && c[0] && c[2]) c[2] = 1'b0;
            bus_wr(p, pdc_pkg::OFF_CTRL, {22'h0, c[3:2], 6'h0, c[1:0]});
            st[p] = nxt(p, st[p], c);
            bus_rd(p, pdc_pkg::OFF_STAT, d);
            chk("status", d, {23'h0, st[p][1], 7'h0, st[p][0]});
            chk("enables", 32'(p ? {tx_en1, rx_en1} : {tx_en0, rx_en0}), 32'(st[p]));
        end
        // chained transfer on both channels with a random item size
        bus_wr(1'b0, pdc_pkg::OFF_CTRL, 32'h0202);
        item_size <= 2'($urandom % 3);
        gap <= 4'($urandom);
        v = $urandom & 32'hfffff000;
        for (int i = 0; i < 8; i++) bus_wr(1'b0, 6'(4 * i), i[0] ? 32'(5 - i / 2) : v + 32'h100 * i);
        bus_wr(1'b0, pdc_pkg::OFF_CTRL, 32'h0101);
        for (int t = 0; t < 3000 && !(flags0.rx_all_full_flag && flags0.tx_all_empty_flag); t++)
            @(posedge clock);
        step = 32'h1 << item_size;
        bus_rd(1'b0, pdc_pkg::OFF_RX_CUR_PTR, d);
        chk("rx pointer", d, v + 32'h400 + 3 * step);
        bus_rd(1'b0, pdc_pkg::OFF_TX_PTR, d);
        chk("tx pointer", d, v + 32'h600 + 2 * step);
        chk("tx mem addr", tx_addr, v + 32'h600 + 2 * step);
        chk("rx mem addr", rx_addr, v + 32'h400 + 3 * step);
        bus_rd(1'b0, pdc_pkg::OFF_RX_NCNT, d);
        chk("rx next count", d, 32'h0);
        bus_rd(1'b0, pdc_pkg::OFF_TX_CNT, d);
        chk("tx count", d, 32'h0);
        chk("end flags", 32'(flags0), 32'hf);
        test_done();
    end

    // watchdog well beyond the fewer than a thousand cycles the sequence needs
    initial begin
        #(20000 * 10);
        errors++;
        test_done();
    end
endmodule
